//--- core/pmic_irq_regs.svh
// Register offsets, reset values, bit groups and timing constants of the
// status and interrupt bank. Assumes one 20 MHz system clock.
`ifndef PMIC_IRQ_REGS_SVH
`define PMIC_IRQ_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_CHG_STATE   8'h01
`define OFS_RAIL_STATE  8'h02
`define OFS_CHG_BLOCK   8'h03
`define OFS_RAIL_BLOCK  8'h04
`define OFS_CHG_TAKEN   8'h05
`define OFS_RAIL_TAKEN  8'h06
`define OFS_CHG_SETUP   8'h07

// ----------------------------------------------------------------------
// Reset values and read answer for unmapped offsets
// ----------------------------------------------------------------------
`define RST_STATE       8'h00
`define RST_BLOCK       8'hff
`define RST_TAKEN       8'h00
`define RST_SETUP       8'h1b
`define RD_UNMAPPED     8'hff

// ----------------------------------------------------------------------
// Bit groups
// ----------------------------------------------------------------------
`define CHG_EDGE_BITS   8'h21
`define RAIL_EDGE_BITS  8'he0
`define CHG_WR_BITS     8'h1e
`define SETUP_TIMER_EN  5
`define CHG_TAPER_BIT   3
`define CHG_FAST_BIT    2
`define SETUP_RESTART   6
`define SYNC_RST        19'h00200  // Idle image of the pins; only the lid pin idles high.

// ----------------------------------------------------------------------
// Timing: taper delay in minutes and the derived cycle count
// ----------------------------------------------------------------------
`define CLK_HZ          64'd20000000
`define TAPER_DELAY_MIN 64'd30
`define TAPER_CYCLES    (`TAPER_DELAY_MIN * 64'd60 * `CLK_HZ)
`define TAPER_W         36
`define PIN_W           19

`endif

//--- core/pmic_irq_pkg.sv
// Types shared by the status and interrupt bank.
// Assumes the constants header is included by the files that need numbers.
package pmic_irq_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [35:0] taper_cnt_t;
endpackage

//--- core/pmic_status_irq_bank.sv
// Status, mask, acknowledge and charger setup registers with the
// active-low interrupt output of a charger and power-rail controller.
// Assumes a register port driven by a serial-bus engine on clk_sys, and
// condition inputs that arrive asynchronously from analog blocks.
//
// What this block does
// - Charger bit 6 is 1 while wall-adapter source is present and valid.
// - Charger bit 5 flags thermal suspend of charging.
// - Charger bit 4 flags termination current crossed and charging stopped.
// - Bit 3 follows taper comparator, or the 30-minute taper timer when enabled.
// - Charger bits 3 to 1 flag taper, fast-charge, precharge timeouts.
// - Charger bit 0 flags battery temperature out of range.
// - Host writes reset charger and clear bits 1-4 written as 0; others ignored.
// - Any unmasked, unacknowledged charger status bit asserts the interrupt output.
// - Rail bit 7 flags a power-button shutdown request.
// - Rail bit 5 flags undervoltage; bit 6 is 1 when lid pin low.
// - Rail bit 4 is 1 when no charging source is present.
// - Rail bits 3,2 flag regulator faults, zero when regulator disabled.
// - Rail bits 1,0 flag converter faults; bit 0 also low-power select in low-power mode.
// - Rail status rising edge drives interrupt low unless masked.
// - Charger mask resets to all ones and blocks matching bits.
// - Rail mask resets to all ones and blocks matching bits.
// - Acknowledged charger bits stop feeding the interrupt output.
// - Charger acknowledge bits clear when their condition goes away.
// - Rail acknowledge resets to zero, gates, clears when condition removed.
// - Charger setup register is read-write and resets to 1Bh.
// - Reading a status register acknowledges every bit read as 1.
// - Edge bits set on rising input, clear after ack with input low.
// - Setup bit 5 enables fast-charge and taper timers.

`include "pmic_irq_regs.svh"

module pmic_status_irq_bank
  import pmic_irq_pkg::*;
#(
  parameter taper_cnt_t TAPER_CYCLES = `TAPER_W'(`TAPER_CYCLES)
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Register port from the serial-bus engine, same clock.
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Charger conditions, asynchronous.
  input  wire logic       usb_source_ok,
  input  wire logic       ac_source_ok,
  input  wire logic       thermal_suspend_in,
  input  wire logic       term_current_in,
  input  wire logic       taper_cmp_in,
  input  wire logic       fast_chg_timeout_in,
  input  wire logic       prechg_timeout_in,
  input  wire logic       batt_temp_err_in,
  // Rail conditions, asynchronous.
  input  wire logic       power_button_request,
  input  wire logic       battery_lid_pin,
  input  wire logic       supply_low_lockout,
  input  wire logic       ldo_b_regulation_fault,
  input  wire logic       ldo_a_regulation_fault,
  input  wire logic       main_rail_regulation_fault,
  input  wire logic       core_rail_regulation_fault,
  input  wire logic       ldo_b_enable,
  input  wire logic       ldo_a_enable,
  input  wire logic       core_lp_select,
  input  wire logic       low_power_mode,
  // Results.
  output logic            irq_n,
  output logic      [7:0] charger_setup,
  output logic            charger_restart
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------

  // Every analog condition passes two flops; only sync_r is read onward.
  // The flops start at each pin's idle level, so a high lid pin gives no false edge.
  logic [`PIN_W-1:0] pin_raw;
  logic [`PIN_W-1:0] meta_r;
  logic [`PIN_W-1:0] sync_r;

  assign pin_raw = {usb_source_ok, ac_source_ok, thermal_suspend_in,
                    term_current_in, taper_cmp_in, fast_chg_timeout_in,
                    prechg_timeout_in, batt_temp_err_in,
                    power_button_request, battery_lid_pin, supply_low_lockout,
                    ldo_b_regulation_fault, ldo_a_regulation_fault,
                    main_rail_regulation_fault, core_rail_regulation_fault,
                    ldo_b_enable, ldo_a_enable, core_lp_select, low_power_mode};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= `SYNC_RST;
      sync_r <= `SYNC_RST;
    end else begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
    end
  end

  // Named views of the synchronised conditions.
  wire s_usb    = sync_r[18];
  wire s_ac     = sync_r[17];
  wire s_therm  = sync_r[16];
  wire s_term   = sync_r[15];
  wire s_taper  = sync_r[14];
  wire s_fast   = sync_r[13];
  wire s_prechg = sync_r[12];
  wire s_temp   = sync_r[11];
  wire s_button = sync_r[10];
  wire s_lid    = sync_r[9];
  wire s_supply_low_lockout   = sync_r[8];
  wire s_ldo_b  = sync_r[7];
  wire s_ldo_a  = sync_r[6];
  wire s_main   = sync_r[5];
  wire s_core   = sync_r[4];
  wire s_ldo_b_en = sync_r[3];
  wire s_ldo_a_en = sync_r[2];
  wire s_core_lp  = sync_r[1];
  wire s_lp_mode  = sync_r[0];

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------

  reg8_t      chg_state_r,  chg_state_nxt;
  reg8_t      rail_state_r, rail_state_nxt;
  reg8_t      chg_block_r,  chg_block_nxt;
  reg8_t      rail_block_r, rail_block_nxt;
  reg8_t      chg_taken_r,  chg_taken_nxt;
  reg8_t      rail_taken_r, rail_taken_nxt;
  reg8_t      setup_r,      setup_nxt;
  reg8_t      rdata_r,      rdata_nxt;
  reg8_t      chg_in_r,     rail_in_r;
  taper_cnt_t taper_cnt_r,  taper_cnt_nxt;
  logic       irq_n_r,      irq_n_nxt;
  logic       restart_r,    restart_nxt;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  wire hit_chg_state  = (reg_addr == `OFS_CHG_STATE);
  wire hit_rail_state = (reg_addr == `OFS_RAIL_STATE);
  wire hit_chg_block  = (reg_addr == `OFS_CHG_BLOCK);
  wire hit_rail_block = (reg_addr == `OFS_RAIL_BLOCK);
  wire hit_chg_taken  = (reg_addr == `OFS_CHG_TAKEN);
  wire hit_rail_taken = (reg_addr == `OFS_RAIL_TAKEN);
  wire hit_setup      = (reg_addr == `OFS_CHG_SETUP);

  // Read data is an if/else-if chain; unmapped offsets answer all ones.
  always_comb begin
    if (hit_chg_state)       rdata_nxt = chg_state_r;
    else if (hit_rail_state) rdata_nxt = rail_state_r;
    else if (hit_chg_block)  rdata_nxt = chg_block_r;
    else if (hit_rail_block) rdata_nxt = rail_block_r;
    else if (hit_chg_taken)  rdata_nxt = chg_taken_r;
    else if (hit_rail_taken) rdata_nxt = rail_taken_r;
    else if (hit_setup)      rdata_nxt = setup_r;
    else                     rdata_nxt = `RD_UNMAPPED;
    if (!reg_rd) rdata_nxt = rdata_r;
  end

  // ----------------------------------------------------------------------
  // Taper timer
  // ----------------------------------------------------------------------

  // The timer only runs while the comparator is high and timers are
  // enabled, and a charger reset restarts it.
  wire timer_en  = setup_r[`SETUP_TIMER_EN];
  wire taper_end = (taper_cnt_r >= TAPER_CYCLES);
  assign taper_cnt_nxt = (!timer_en || !s_taper || restart_r) ? '0 :
                         taper_end ? taper_cnt_r : taper_cnt_r + 1'b1;

  // ----------------------------------------------------------------------
  // Condition vectors
  // ----------------------------------------------------------------------

  // Bit 3 choice between raw comparator and expired timer.
  wire taper_flag = timer_en ? taper_end : s_taper;
  // Fast-charge timeout only counts while its timer is enabled.
  wire fast_flag  = timer_en & s_fast;

  reg8_t chg_in, rail_in;
  assign chg_in = {s_usb, s_ac,
                   s_therm,
                   s_term,
                   taper_flag, fast_flag, s_prechg,
                   s_temp};
  assign rail_in = {s_button,
                    ~s_lid, s_supply_low_lockout,
                    ~(s_usb | s_ac),
                    s_ldo_b & s_ldo_b_en,
                    s_ldo_a & s_ldo_a_en,
                    s_main,
                    s_core | (s_core_lp & s_lp_mode)};

  // ----------------------------------------------------------------------
  // Status and acknowledge update
  // ----------------------------------------------------------------------

  // Rising edges are taken against the previous condition sample.
  wire reg8_t chg_rise  = chg_in  & ~chg_in_r;
  wire reg8_t rail_rise = rail_in & ~rail_in_r;

  // A host write to the charger status clears bits 1 to 4 written as 0
  // and pulses the charger restart; bits 0 and 5 to 7 ignore the write.
  wire   chg_wr_hit = reg_wr & hit_chg_state;
  wire reg8_t chg_wr_clr = chg_wr_hit ? (`CHG_WR_BITS & ~reg_wdata) : 8'h00;
  assign restart_nxt = chg_wr_hit | setup_r[`SETUP_RESTART];

  // Edge bits hold until acknowledged with the input low; a rise in the
  // same cycle wins. Level bits follow their input.
  wire reg8_t chg_hold  = chg_state_r  & ~(~chg_in  & chg_taken_r);
  wire reg8_t rail_hold = rail_state_r & ~(~rail_in & rail_taken_r);
  assign chg_state_nxt  = ((`CHG_EDGE_BITS & (chg_rise | chg_hold))
                        | (~`CHG_EDGE_BITS & chg_in)) & ~chg_wr_clr;
  assign rail_state_nxt = (`RAIL_EDGE_BITS & (rail_rise | rail_hold))
                        | (~`RAIL_EDGE_BITS & rail_in);

  // A status read acknowledges what it returned; acknowledges drop once
  // the status bit is clear, so a fresh event is never hidden.
  wire reg8_t chg_rd_ack  = (reg_rd & hit_chg_state)  ? chg_state_r  : 8'h00;
  wire reg8_t rail_rd_ack = (reg_rd & hit_rail_state) ? rail_state_r : 8'h00;
  assign chg_taken_nxt  = (chg_taken_r  | chg_rd_ack)  & chg_state_nxt;
  assign rail_taken_nxt = (rail_taken_r | rail_rd_ack) & rail_state_nxt;

  // ----------------------------------------------------------------------
  // Mask and setup writes
  // ----------------------------------------------------------------------

  assign chg_block_nxt  = (reg_wr & hit_chg_block)  ? reg_wdata : chg_block_r;
  assign rail_block_nxt = (reg_wr & hit_rail_block) ? reg_wdata : rail_block_r;
  assign setup_nxt      = (reg_wr & hit_setup)      ? reg_wdata : setup_r;

  // ----------------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------------

  // Pending means set, unmasked and not yet acknowledged; the pin lags
  // the status by one cycle so that it comes straight from a flop.
  wire reg8_t chg_pend  = chg_state_r  & ~chg_block_r  & ~chg_taken_r;
  wire reg8_t rail_pend = rail_state_r & ~rail_block_r & ~rail_taken_r;
  assign irq_n_nxt = ~(|chg_pend | |rail_pend);

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------

  // Status, acknowledges and condition history.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chg_state_r  <= `RST_STATE;
      rail_state_r <= `RST_STATE;
      chg_taken_r  <= `RST_TAKEN;
      rail_taken_r <= `RST_TAKEN;
      chg_in_r     <= 8'h00;
      rail_in_r    <= 8'h00;
    end else begin
      chg_state_r  <= chg_state_nxt;
      rail_state_r <= rail_state_nxt;
      chg_taken_r  <= chg_taken_nxt;
      rail_taken_r <= rail_taken_nxt;
      chg_in_r     <= chg_in;
      rail_in_r    <= rail_in;
    end
  end

  // Software-written registers; masks start all ones so nothing fires.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chg_block_r  <= `RST_BLOCK;
      rail_block_r <= `RST_BLOCK;
      setup_r      <= `RST_SETUP;
    end else begin
      chg_block_r  <= chg_block_nxt;
      rail_block_r <= rail_block_nxt;
      setup_r      <= setup_nxt;
    end
  end

  // Timer, read data and output flops.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      taper_cnt_r <= '0;
      rdata_r     <= `RD_UNMAPPED;
      irq_n_r     <= 1'b1;
      restart_r   <= 1'b0;
    end else begin
      taper_cnt_r <= taper_cnt_nxt;
      rdata_r     <= rdata_nxt;
      irq_n_r     <= irq_n_nxt;
      restart_r   <= restart_nxt;
    end
  end

  assign reg_rdata       = rdata_r;
  assign irq_n           = irq_n_r;
  assign charger_setup   = setup_r;
  assign charger_restart = restart_r;

endmodule

//--- verif/pmic_status_irq_bank_monitor.sv
// Concurrent checks on the register port and result outputs of the bank.
// Assumes it is bound to the bank and sees only the bank's ports.
module pmic_status_irq_bank_monitor
  import pmic_irq_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_n,
  input wire logic [7:0] charger_setup,
  input wire logic       charger_restart
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A setup write and the read that follows it form the round trip checked below.
  sequence setup_wr; reg_wr && reg_addr == 8'h07; endsequence
  sequence setup_rd; reg_rd && reg_addr == 8'h07; endsequence
  reset_values_a: assert property (
    $rose(rst_n) |-> irq_n && charger_setup == 8'h1b) else $error("outputs wrong after reset");
  unmapped_read_a: assert property (
    reg_rd && (reg_addr == 8'h00 || reg_addr > 8'h07) |=> reg_rdata == 8'hff)
    else $error("unmapped read not ff");
  setup_write_a: assert property (setup_wr |=> charger_setup == $past(reg_wdata))
    else $error("setup write lost");
  setup_hold_a: assert property (
    !(reg_wr && reg_addr == 8'h07) |=> $stable(charger_setup))
    else $error("setup changed without write");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  setup_readback_a: assert property (
    setup_rd |=> reg_rdata == $past(charger_setup)) else $error("setup read wrong");
  setup_echo_a: assert property (
    setup_wr ##3 setup_rd |=> reg_rdata == $past(reg_wdata, 4))
    else $error("setup round trip wrong");
  restart_pulse_a: assert property (
    reg_wr && reg_addr == 8'h01 && reg_wdata[4:1] == 4'h0 |-> ##[1:2] charger_restart)
    else $error("no charger restart");
  restart_mirror_a: assert property (
    charger_setup[6] && $past(charger_setup[6]) |-> charger_restart)
    else $error("restart not following setup");
endmodule

bind pmic_status_irq_bank pmic_status_irq_bank_monitor pmic_status_irq_bank_monitor_inst (
  .clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .irq_n,
  .charger_setup, .charger_restart);

//--- verif/host_bus_model.sv
// Host side of the register port: one-cycle strobes for reads and writes.
// Assumes callers enter the task just after a rising clock edge.
module host_bus_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle lines carry the inverse of the last value, so stale values never look valid.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One access: strobe for one edge, then take read data one edge later.
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w,
                        output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clk_sys);
    #1;
    q = reg_rdata;
  endtask
endmodule

//--- verif/pmic_status_irq_bank_bench.sv
// Self-checking bench for the status and interrupt bank.
// Assumes the host model drives the register port; conditions are driven here.
module pmic_status_irq_bank_bench import pmic_irq_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [18:0] c; reg8_t chg; reg8_t rail;} row_t;
  logic        clk_sys, rst_n, reg_wr, reg_rd, irq_n, charger_restart;
  logic [18:0] cond;
  reg8_t       reg_addr, reg_wdata, reg_rdata, charger_setup;
  int          err_count, check_count;
  // Condition rows; edge bits clear once read, as soon as their input is low, even if read while high.
  row_t rows [7] = '{'{19'h08000, 8'h00, 8'h10}, '{19'h080de, 8'hda, 8'h00},
    '{19'h0ae80, 8'h80, 8'h0a}, '{19'h140a1, 8'ha1, 8'he0}, '{19'h28080, 8'h80, 8'h00},
    '{19'h68080, 8'h80, 8'h01}, '{19'h09440, 8'h40, 8'h04}};

  // A short taper count keeps the timed taper case within a few dozen cycles.
  pmic_status_irq_bank #(.TAPER_CYCLES(36'd20)) pmic_status_irq_bank_inst (
    .clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .batt_temp_err_in(cond[0]), .prechg_timeout_in(cond[1]), .fast_chg_timeout_in(cond[2]),
    .taper_cmp_in(cond[3]), .term_current_in(cond[4]), .thermal_suspend_in(cond[5]),
    .ac_source_ok(cond[6]), .usb_source_ok(cond[7]), .core_rail_regulation_fault(cond[8]),
    .main_rail_regulation_fault(cond[9]), .ldo_a_regulation_fault(cond[10]),
    .ldo_b_regulation_fault(cond[11]), .ldo_a_enable(cond[12]), .ldo_b_enable(cond[13]),
    .supply_low_lockout(cond[14]), .battery_lid_pin(cond[15]),
    .power_button_request(cond[16]), .core_lp_select(cond[17]), .low_power_mode(cond[18]),
    .irq_n, .charger_setup, .charger_restart);
  host_bus_model host_bus_model_inst (.clk_sys, .reg_rdata, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata);

  task automatic chk(input string what, input reg8_t exp, input reg8_t got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input reg8_t a, input reg8_t exp, input string what);
    reg8_t q;
    host_bus_model_inst.access(a, 8'h00, 1'b0, q);
    chk(what, exp, q);
  endtask
  task automatic wr(input reg8_t a, input reg8_t d);
    reg8_t q;
    host_bus_model_inst.access(a, d, 1'b1, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Clock and watchdog; the whole sequence needs well under a thousand cycles.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    end_of_test();
  end
  // Main sequence: reset values, condition rows, then interrupt and write cases.
  initial begin
    rst_n = 1'b0;
    cond = 19'h08000;
    cyc(4);
    rst_n = 1'b1;
    rd(8'h03, 8'hff, "chg mask");
    rd(8'h04, 8'hff, "rail mask");
    rd(8'h05, 8'h00, "chg ack");
    rd(8'h06, 8'h00, "rail ack");
    rd(8'h07, 8'h1b, "setup");
    rd(8'h20, 8'hff, "unmapped");
    foreach (rows[i]) begin
      cond = rows[i].c;
      cyc(6);
      rd(8'h01, rows[i].chg, "chg status");
      rd(8'h02, rows[i].rail, "rail status");
      chk("irq_n", 8'h01, {7'h00, irq_n});
    end
    cond = 19'h08080;
    cyc(6);
    rd(8'h01, 8'h80, "chg status");
    wr(8'h03, 8'h7f);
    cyc(3);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    cond = 19'h080c0;
    cyc(6);
    wr(8'h03, 8'h3f);
    cyc(3);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    rd(8'h05, 8'h80, "chg ack");
    rd(8'h01, 8'hc0, "chg status");
    cyc(2);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    rd(8'h05, 8'hc0, "chg ack");
    cond = 19'h08040;
    cyc(6);
    rd(8'h05, 8'h40, "chg ack");
    wr(8'h04, 8'hef);
    cond = 19'h08000;
    cyc(6);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    rd(8'h06, 8'h00, "rail ack");
    rd(8'h02, 8'h10, "rail status");
    cyc(2);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    rd(8'h06, 8'h10, "rail ack");
    cond = 19'h08040;
    cyc(6);
    rd(8'h06, 8'h00, "rail ack");
    cond[16] = 1'b1;
    cyc(4);
    cond[16] = 1'b0;
    cyc(6);
    rd(8'h02, 8'h80, "rail status");
    cyc(3);
    rd(8'h02, 8'h00, "rail status");
    wr(8'h02, 8'hff);
    wr(8'h05, 8'hff);
    wr(8'h06, 8'hff);
    wr(8'h01, 8'hff);
    rd(8'h02, 8'h00, "rail status");
    rd(8'h05, 8'h00, "chg ack");
    rd(8'h06, 8'h00, "rail ack");
    rd(8'h01, 8'h40, "chg status");
    cond = 19'h08048;
    cyc(6);
    wr(8'h01, 8'h00);
    cyc(6);
    rd(8'h01, 8'h48, "chg status");
    cond = 19'h08040;
    wr(8'h07, 8'h7b);
    rd(8'h07, 8'h7b, "setup");
    wr(8'h07, 8'h3b);
    cond = 19'h0804c;
    cyc(6);
    rd(8'h01, 8'h44, "chg status");
    cyc(25);
    rd(8'h01, 8'h4c, "chg status");
    // A charger-status write restarts the taper timer, so the timed bit 3 drops.
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h44, "chg status");
    rst_n = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    rd(8'h07, 8'h1b, "setup");
    rd(8'h03, 8'hff, "chg mask");
    end_of_test();
  end
endmodule
